// [logic/adc_control_status_unit.sv]
// Summary of operation
// - single mode: set end flag when the selected channel finishes converting
// - scan mode: set end flag only after every channel of the group finished
// - writing 0 after reading flag as 1 clears it; writing 1 does nothing
// - transfer controller reading a result register also clears the end flag
// - with interrupt enable 1, a set end flag requests the interrupt
// - start bit 1 begins conversion; 0 halts and enters wait state
// - single mode: start bit clears itself when the channel conversion ends
// - scan mode: convert group repeatedly until start cleared, reset or standby
// - bit 4 of control/status always reads zero; software writes zero
// - channel field bits 3..0 combine with scan enable and group select
// - scan off: codes 0..7 pick one input; top bit set is prohibited
// - scan on, group 0: codes 0..3 scan from input 0, 4..7 from 4
// - scan on, group 1: code n scan_group_select inputs 0 through n
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adc_control_status_unit (
   input  wire logic                           clk,
   input  wire logic                           sys_rst,
   input  wire logic                           hw_standby,
   input  wire logic [7:0]                     s_axi_awaddr,
   input  wire logic                           s_axi_awvalid,
   output var  logic                           s_axi_awready,
   input  wire logic [31:0]                    s_axi_wdata,
   input  wire logic [3:0]                     s_axi_wstrb,
   input  wire logic                           s_axi_wvalid,
   output var  logic                           s_axi_wready,
   output var  logic [1:0]                     s_axi_bresp,
   output var  logic                           s_axi_bvalid,
   input  wire logic                           s_axi_bready,
   input  wire logic [7:0]                     s_axi_araddr,
   input  wire logic                           s_axi_arvalid,
   output var  logic                           s_axi_arready,
   output var  logic [31:0]                    s_axi_rdata,
   output var  logic [1:0]                     s_axi_rresp,
   output var  logic                           s_axi_rvalid,
   input  wire logic                           s_axi_rready,
   input  wire logic                           xfer_master_rd,
   input  wire logic                           ext_trigger_pin,
   output var  logic                           conv_start,
   output var  logic                           conv_abort,
   output var  logic [2:0]                     conv_channel,
   input  wire logic                           conv_done,
   input  wire logic [adc_ctl_pkg::RES_W-1:0]  conv_result,
   output var  logic                           conversion_end_interrupt
);
   logic                        clr;
   adc_ctl_pkg::csr_t           csr_r;
   adc_ctl_pkg::cfg_t           cfg_r;
   adc_ctl_pkg::seq_state_t     state_r;
   logic [2:0]                  cur_ch_r;
   logic [adc_ctl_pkg::RES_W-1:0] data_r [adc_ctl_pkg::NUM_CH];
   logic                        flag_read_r;
   logic                        flag_nxt;
   logic                        ie_nxt;
   logic                        trg_s1_r;
   logic                        trg_s2_r;
   logic                        trg_d_r;
   logic                        trg_edge;
   logic                        aw_hold_r;
   logic                        w_hold_r;
   logic                        ar_hold_r;
   logic                        ar_xfer_r;
   logic [7:0]                  aw_addr_r;
   logic [7:0]                  ar_addr_r;
   logic [31:0]                 w_data_r;
   logic [3:0]                  w_strb_r;
   logic                        wr_fire;
   logic                        rd_fire;
   logic                        wr_csr;
   logic                        wr_cfg;
   adc_ctl_pkg::reg_sel_t       wr_sel;
   adc_ctl_pkg::reg_sel_t       rd_sel;
   logic [2:0]                  first_ch;
   logic [2:0]                  last_ch;
   logic                        conv_ev;
   logic                        group_end;
   logic                        flag_set;
   logic                        clear_sw;
   logic                        clear_dma;
   logic                        seq_drop_start;

   function automatic adc_ctl_pkg::reg_sel_t decode(input logic [7:0] a);
      if (a == adc_ctl_pkg::CSR_OFS) begin
         decode = adc_ctl_pkg::SEL_CSR;
      end else if (a == adc_ctl_pkg::CFG_OFS) begin
         decode = adc_ctl_pkg::SEL_CFG;
      end else if (a >= adc_ctl_pkg::DATA_OFS && a <= adc_ctl_pkg::DATA_END_OFS && a[1:0] == 2'h0) begin
         decode = adc_ctl_pkg::SEL_DATA;
      end else begin
         decode = adc_ctl_pkg::SEL_NONE;
      end
   endfunction

   assign clr = sys_rst | hw_standby;

   // external trigger pin synchroniser and edge detect
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trg_s1_r <= 1'b0;
         trg_s2_r <= 1'b0;
         trg_d_r  <= 1'b0;
      end else begin
         trg_s1_r <= ext_trigger_pin;
         trg_s2_r <= trg_s1_r;
         trg_d_r  <= trg_s2_r;
      end
   end
   assign trg_edge = trg_s2_r & ~trg_d_r & cfg_r.ext_trigger_enable;

   // write address/data channels, accepted in either order
   assign wr_fire = aw_hold_r & w_hold_r & ~s_axi_bvalid;
   assign wr_sel  = decode(aw_addr_r);
   assign wr_csr  = wr_fire & (wr_sel == adc_ctl_pkg::SEL_CSR) & w_strb_r[0];
   assign wr_cfg  = wr_fire & (wr_sel == adc_ctl_pkg::SEL_CFG) & w_strb_r[0];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aw_hold_r     <= 1'b0;
         s_axi_awready <= 1'b0;
         aw_addr_r     <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_r     <= 1'b1;
         s_axi_awready <= 1'b0;
         aw_addr_r     <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_hold_r <= 1'b0;
      end else if (!aw_hold_r && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         w_hold_r     <= 1'b0;
         s_axi_wready <= 1'b0;
         w_data_r     <= 32'h0000_0000;
         w_strb_r     <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_r     <= 1'b1;
         s_axi_wready <= 1'b0;
         w_data_r     <= s_axi_wdata;
         w_strb_r     <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_hold_r <= 1'b0;
      end else if (!w_hold_r && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= adc_ctl_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_sel == adc_ctl_pkg::SEL_CSR || wr_sel == adc_ctl_pkg::SEL_CFG) ?
                         adc_ctl_pkg::RESP_OKAY : adc_ctl_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read channel
   assign rd_fire = ar_hold_r & ~s_axi_rvalid;
   assign rd_sel  = decode(ar_addr_r);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ar_hold_r     <= 1'b0;
         ar_xfer_r     <= 1'b0;
         s_axi_arready <= 1'b0;
         ar_addr_r     <= 8'h00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         ar_hold_r     <= 1'b1;
         ar_xfer_r     <= xfer_master_rd;
         s_axi_arready <= 1'b0;
         ar_addr_r     <= s_axi_araddr;
      end else if (rd_fire) begin
         ar_hold_r <= 1'b0;
      end else if (!ar_hold_r && !s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= adc_ctl_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= adc_ctl_pkg::RESP_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
         case (rd_sel)
            adc_ctl_pkg::SEL_CSR: begin
               s_axi_rdata[7:0] <= {csr_r.conversion_end_flag, csr_r.end_interrupt_enable,
                                    csr_r.conversion_start_bit, 1'b0, csr_r.channel_select};
            end
            adc_ctl_pkg::SEL_CFG: begin
               s_axi_rdata[2:0] <= cfg_r;
            end
            adc_ctl_pkg::SEL_DATA: begin
               s_axi_rdata[adc_ctl_pkg::RES_W-1:0] <= data_r[ar_addr_r[4:2]];
            end
            default: begin
               s_axi_rresp <= adc_ctl_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // scan group limits from channel field, scan enable and group select
   always_comb begin
      last_ch = csr_r.channel_select[2:0];
      if (!cfg_r.scan_enable_bit) begin
         first_ch = csr_r.channel_select[2:0];
      end else if (!cfg_r.scan_group_select && csr_r.channel_select[2]) begin
         first_ch = adc_ctl_pkg::SCAN_HIGH_FIRST;
      end else begin
         first_ch = adc_ctl_pkg::SCAN_LOW_FIRST;
      end
   end

   assign conv_ev   = (state_r == adc_ctl_pkg::SEQ_CONV) & conv_done & csr_r.conversion_start_bit;
   assign group_end = conv_ev & (~cfg_r.scan_enable_bit | (cur_ch_r == last_ch));
   assign flag_set  = group_end;
   // prohibited codes (top bit set) never start and drop the start bit
   assign seq_drop_start = (state_r == adc_ctl_pkg::SEQ_IDLE) & csr_r.conversion_start_bit &
                           csr_r.channel_select[adc_ctl_pkg::CH_MSB];

   // conversion sequencer
   always_ff @(posedge clk) begin
      if (clr) begin
         state_r      <= adc_ctl_pkg::SEQ_IDLE;
         cur_ch_r     <= 3'h0;
         conv_start   <= 1'b0;
         conv_abort   <= 1'b0;
         conv_channel <= 3'h0;
      end else begin
         conv_start <= 1'b0;
         conv_abort <= 1'b0;
         case (state_r)
            adc_ctl_pkg::SEQ_IDLE: begin
               if (csr_r.conversion_start_bit && !csr_r.channel_select[adc_ctl_pkg::CH_MSB]) begin
                  state_r      <= adc_ctl_pkg::SEQ_CONV;
                  cur_ch_r     <= first_ch;
                  conv_channel <= first_ch;
                  conv_start   <= 1'b1;
               end
            end
            adc_ctl_pkg::SEQ_CONV: begin
               if (!csr_r.conversion_start_bit) begin
                  state_r    <= adc_ctl_pkg::SEQ_IDLE;
                  conv_abort <= 1'b1;
               end else if (conv_done) begin
                  if (!cfg_r.scan_enable_bit) begin
                     state_r <= adc_ctl_pkg::SEQ_IDLE;
                  end else if (cur_ch_r == last_ch) begin
                     cur_ch_r     <= first_ch;
                     conv_channel <= first_ch;
                     conv_start   <= 1'b1;
                  end else begin
                     cur_ch_r     <= cur_ch_r + 3'h1;
                     conv_channel <= cur_ch_r + 3'h1;
                     conv_start   <= 1'b1;
                  end
               end
            end
            default: begin
               state_r <= adc_ctl_pkg::SEQ_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (conv_ev) begin
         data_r[cur_ch_r] <= conv_result;
      end
   end

   // end flag: a set in the same cycle as a clear wins
   assign clear_sw  = wr_csr & ~w_data_r[adc_ctl_pkg::FLAG_BIT] & flag_read_r;
   assign clear_dma = rd_fire & ar_xfer_r & (rd_sel == adc_ctl_pkg::SEL_DATA);

   always_comb begin
      flag_nxt = flag_set | (csr_r.conversion_end_flag & ~(clear_sw | clear_dma));
      ie_nxt   = wr_csr ? w_data_r[adc_ctl_pkg::IE_BIT] : csr_r.end_interrupt_enable;
      if (clr) begin
         flag_nxt = 1'b0;
         ie_nxt   = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (clr) begin
         csr_r       <= adc_ctl_pkg::CSR_RST;
         flag_read_r <= 1'b0;
      end else begin
         csr_r.conversion_end_flag  <= flag_nxt;
         csr_r.end_interrupt_enable <= ie_nxt;
         csr_r.rsvd                 <= 1'b0;
         if (wr_csr) begin
            csr_r.channel_select       <= w_data_r[adc_ctl_pkg::CH_MSB:0];
            csr_r.conversion_start_bit <= w_data_r[adc_ctl_pkg::START_BIT];
         end else if (trg_edge) begin
            csr_r.conversion_start_bit <= 1'b1;
         end else if ((group_end && !cfg_r.scan_enable_bit) || seq_drop_start) begin
            csr_r.conversion_start_bit <= 1'b0;
         end
         if (wr_csr) begin
            flag_read_r <= 1'b0;
         end else if (rd_fire && rd_sel == adc_ctl_pkg::SEL_CSR && csr_r.conversion_end_flag) begin
            flag_read_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (clr) begin
         cfg_r <= adc_ctl_pkg::CFG_RST;
      end else if (wr_cfg) begin
         cfg_r <= w_data_r[2:0];
      end
   end

   always_ff @(posedge clk) begin
      if (clr) begin
         conversion_end_interrupt <= 1'b0;
      end else begin
         conversion_end_interrupt <= flag_nxt & ie_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_single_flag;
      conv_ev && !cfg_r.scan_enable_bit |=> csr_r.conversion_end_flag || $past(hw_standby);
   endproperty
   a_single_flag: assert property (p_single_flag) else $error("single end did not set flag");

   property p_scan_mid;
      conv_ev && cfg_r.scan_enable_bit && cur_ch_r != last_ch && !csr_r.conversion_end_flag
         |=> !csr_r.conversion_end_flag;
   endproperty
   a_scan_mid: assert property (p_scan_mid) else $error("flag set before scan group end");

   property p_write_one;
      wr_csr && w_data_r[adc_ctl_pkg::FLAG_BIT] && !csr_r.conversion_end_flag && !flag_set && !hw_standby
         |=> !csr_r.conversion_end_flag;
   endproperty
   a_write_one: assert property (p_write_one) else $error("writing one set the flag");

   property p_sw_clear;
      clear_sw && !flag_set |=> !csr_r.conversion_end_flag;
   endproperty
   a_sw_clear: assert property (p_sw_clear) else $error("software clear failed");

   property p_dma_clear;
      clear_dma && !flag_set |=> !csr_r.conversion_end_flag;
   endproperty
   a_dma_clear: assert property (p_dma_clear) else $error("transfer read did not clear flag");

   property p_irq;
      conversion_end_interrupt == (csr_r.conversion_end_flag & csr_r.end_interrupt_enable);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not flag and enable");

   property p_halt;
      wr_csr && !w_data_r[adc_ctl_pkg::START_BIT] && state_r == adc_ctl_pkg::SEQ_CONV
         |=> !csr_r.conversion_start_bit ##1 state_r == adc_ctl_pkg::SEQ_IDLE;
   endproperty
   a_halt: assert property (p_halt) else $error("start clear did not halt");

   property p_single_stop;
      group_end && !cfg_r.scan_enable_bit && !wr_csr && !trg_edge |=> !csr_r.conversion_start_bit;
   endproperty
   a_single_stop: assert property (p_single_stop) else $error("start bit not self cleared");

   property p_scan_repeat;
      group_end && cfg_r.scan_enable_bit && !clr |=> conv_start && conv_channel == $past(first_ch);
   endproperty
   a_scan_repeat: assert property (p_scan_repeat) else $error("scan did not restart group");

   property p_rsvd_zero;
      s_axi_rvalid && rd_sel == adc_ctl_pkg::SEL_CSR |-> !s_axi_rdata[adc_ctl_pkg::RSVD_BIT];
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one");

   property p_group0_high;
      state_r == adc_ctl_pkg::SEQ_IDLE && csr_r.conversion_start_bit && !clr && cfg_r.scan_enable_bit
         && !cfg_r.scan_group_select && csr_r.channel_select[3:2] == 2'h1 |=> conv_channel == 3'h4;
   endproperty
   a_group0_high: assert property (p_group0_high) else $error("group 0 high scan wrong start");

   property p_chan_range;
      conv_start |-> conv_channel <= csr_r.channel_select[2:0];
   endproperty
   a_chan_range: assert property (p_chan_range) else $error("channel outside selected range");

   property p_standby;
      hw_standby |=> csr_r == adc_ctl_pkg::CSR_RST && state_r == adc_ctl_pkg::SEQ_IDLE;
   endproperty
   a_standby: assert property (p_standby) else $error("standby did not clear");

   c_single: cover property (group_end && !cfg_r.scan_enable_bit);
   c_scan_wrap: cover property (group_end && cfg_r.scan_enable_bit ##[1:40] group_end);
   c_dma_clear: cover property (clear_dma && csr_r.conversion_end_flag);
   c_set_clear: cover property (flag_set && clear_sw);
endmodule
`default_nettype wire

// [logic/adc_ctl_pkg.sv]
`default_nettype none
package adc_ctl_pkg;
   // byte addresses on the register bus
   localparam logic [7:0] CSR_OFS      = 8'h00;
   localparam logic [7:0] CFG_OFS      = 8'h04;
   localparam logic [7:0] DATA_OFS     = 8'h20;
   localparam logic [7:0] DATA_END_OFS = 8'h3C;
   localparam int         ADDR_W       = 8;
   // control/status field positions
   localparam int FLAG_BIT  = 7;
   localparam int IE_BIT    = 6;
   localparam int START_BIT = 5;
   localparam int RSVD_BIT  = 4;
   localparam int CH_MSB    = 3;
   // configuration field positions
   localparam int SCAN_EN_BIT  = 0;
   localparam int GROUP_BIT    = 1;
   localparam int EXT_TRIG_BIT = 2;
   // values after reset, scan start channels, channel count, result width and bus responses
   localparam logic [7:0] CSR_RST = 8'h00;
   localparam logic [2:0] CFG_RST = 3'h0;
   localparam logic [2:0] SCAN_HIGH_FIRST = 3'h4;
   localparam logic [2:0] SCAN_LOW_FIRST  = 3'h0;
   localparam int NUM_CH = 8;
   localparam int RES_W  = 10;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic       conversion_end_flag;
      logic       end_interrupt_enable;
      logic       conversion_start_bit;
      logic       rsvd;
      logic [3:0] channel_select;
   } csr_t;

   typedef struct packed {
      logic ext_trigger_enable;
      logic scan_group_select;
      logic scan_enable_bit;
   } cfg_t;

   typedef enum logic [1:0] {SEL_NONE, SEL_CSR, SEL_CFG, SEL_DATA} reg_sel_t;
   typedef enum {SEQ_IDLE, SEQ_CONV} seq_state_t;
endpackage
`default_nettype wire

// [sim/conv_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
   input  wire logic                          clk,
   input  wire logic [3:0]                    lat,
   input  wire logic                          conv_start,
   input  wire logic                          conv_abort,
   input  wire logic [2:0]                    conv_channel,
   output var  logic                          conv_done,
   output var  logic [adc_ctl_pkg::RES_W-1:0] conv_result
);
   logic       busy_r = 1'b0;
   logic [3:0] cnt_r = 4'h0;
   logic [2:0] ch_r = 3'h0;
   initial conv_done = 1'b0;
   initial conv_result = 10'h000;
   // result bus toggles outside the done pulse so a late sample cannot pass
   always @(posedge clk) begin
      conv_done <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_abort) begin
         busy_r <= 1'b0;
      end else if (conv_start) begin
         busy_r <= 1'b1;
         cnt_r <= lat;
         ch_r <= conv_channel;
      end else if (busy_r && cnt_r == 4'h0) begin
         busy_r <= 1'b0;
         conv_done <= 1'b1;
         conv_result <= {ch_r, 7'h15};
      end else if (busy_r) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
endmodule
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [7:0] CSR = adc_ctl_pkg::CSR_OFS;
   localparam logic [7:0] CFG = adc_ctl_pkg::CFG_OFS;
   localparam logic [7:0] DAT = adc_ctl_pkg::DATA_OFS;
   localparam logic [1:0] OK = adc_ctl_pkg::RESP_OKAY;
   logic        clk = 1'b0, sys_rst = 1'b1, stby = 1'b0, xm = 1'b0, trg = 1'b0;
   logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rd_d, v;
   logic [3:0]  lat = 4'h3;
   logic        awr, wrdy, bv, arr, rv, cst, cab, cdn, irq;
   logic [1:0]  br, rr;
   logic [2:0]  cch;
   logic [9:0]  cres;
   logic [2:0]  chq[$];
   logic [2:0]  scodes[4] = '{3'h3, 3'h6, 3'h7, 3'h2};
   int          err_count = 0, samples_checked = 0, n_abort = 0;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (cst) begin
         chq.push_back(cch);
      end
      if (cab) begin
         n_abort++;
      end
   end
   adc_control_status_unit uut (.clk(clk), .sys_rst(sys_rst), .hw_standby(stby), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .xfer_master_rd(xm), .ext_trigger_pin(trg), .conv_start(cst), .conv_abort(cab),
      .conv_channel(cch), .conv_done(cdn), .conv_result(cres), .conversion_end_interrupt(irq));
   conv_core_model core (.clk(clk), .lat(lat), .conv_start(cst), .conv_abort(cab), .conv_channel(cch),
      .conv_done(cdn), .conv_result(cres));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic hang(input string what);
      chk(what, 32'h1, 32'h0);
      wrap_up();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         if (awr && !aw_ok) begin
            aw_ok = 1'b1;
            awv <= 1'b0;
         end
         if (wrdy && !w_ok) begin
            w_ok = 1'b1;
            wv <= 1'b0;
         end
         if (bv) begin
            bry <= 1'b0;
            chk("bresp", 32'(er), 32'(br));
            return;
         end
      end
      hang("write_timeout");
   endtask
   task automatic rd(input logic [7:0] a, input logic x, input logic [1:0] er);
      @(posedge clk);
      ara <= a;
      xm <= x;
      arv <= 1'b1;
      rry <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         if (arr) begin
            arv <= 1'b0;
            xm <= 1'b0;
         end
         if (rv) begin
            rry <= 1'b0;
            v = rd_d;
            chk("rresp", 32'(er), 32'(rr));
            return;
         end
      end
      hang("read_timeout");
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      rd(a, 1'b0, OK);
      chk(what, exp, v);
   endtask
   task automatic poll_flag;
      for (int n = 0; n < 60; n++) begin
         rd(CSR, 1'b0, OK);
         if (v[7] === 1'b1) begin
            return;
         end
      end
      hang("flag_timeout");
   endtask
   // zero waits for the interrupt, otherwise for that many conversion starts
   task automatic wait_for(input int n);
      for (int i = 0; i < 400; i++) begin
         @(posedge clk);
         if (n == 0 ? irq === 1'b1 : chq.size() >= n) begin
            return;
         end
      end
      hang("wait_timeout");
   endtask
   task automatic idle_check(input string what);
      int sz;
      repeat (3) @(posedge clk);
      sz = chq.size();
      repeat (40) @(posedge clk);
      chk(what, 32'(sz), 32'(chq.size()));
   endtask
   initial begin
      int n;
      int base;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      rdchk(CSR, 32'h00, "csr_reset");
      rdchk(CFG, 32'h00, "cfg_reset");
      rd(8'h10, 1'b0, adc_ctl_pkg::RESP_SLVERR);
      wr(CSR, 32'h17, OK);
      rdchk(CSR, 32'h07, "csr_reserved");
      for (int c = 0; c < 8; c++) begin
         chq.delete();
         wr(CSR, 32'h20 | c, OK);
         poll_flag();
         chk("single_csr", 32'h80 | c, v);
         chk("single_count", 32'h1, 32'(chq.size()));
         chk("single_ch", 32'(c), 32'(chq[0]));
         chk("irq_masked", 32'h0, 32'(irq));
         rdchk(DAT + 8'(4 * c), 32'({3'(c), 7'h15}), "result");
         wr(CSR, 32'(c), OK);
         rdchk(CSR, 32'(c), "flag_clear");
      end
      wr(CSR, 32'h62, OK);
      wait_for(0);
      wr(CSR, 32'h42, OK);
      chk("irq_held", 32'h1, 32'(irq));
      rdchk(CSR, 32'hC2, "flag_unread_write");
      wr(CSR, 32'hC2, OK);
      rdchk(CSR, 32'hC2, "flag_write_one");
      wr(CSR, 32'h42, OK);
      rdchk(CSR, 32'h42, "flag_clear_ie");
      chk("irq_drop", 32'h0, 32'(irq));
      wr(CSR, 32'h63, OK);
      wait_for(0);
      rd(DAT + 8'h0C, 1'b1, OK);
      rdchk(CSR, 32'h43, "flag_xfer_clear");
      chq.delete();
      wr(CSR, 32'h28, OK);
      repeat (20) @(posedge clk);
      chk("bad_code_conv", 32'h0, 32'(chq.size()));
      rdchk(CSR, 32'h08, "bad_code_start");
      wr(CSR, 32'h05, OK);
      wr(CFG, 32'h04, OK);
      chq.delete();
      trg <= 1'b1;
      repeat (4) @(posedge clk);
      trg <= 1'b0;
      poll_flag();
      chk("trig_csr", 32'h85, v);
      chk("trig_ch", 32'h5, 32'(chq[0]));
      chk("trig_count", 32'h1, 32'(chq.size()));
      wr(CFG, 32'h00, OK);
      wr(CSR, 32'h05, OK);
      rdchk(CSR, 32'h05, "trig_clear");
      lat <= 4'h6;
      for (int k = 0; k < 4; k++) begin
         base = (k < 2 && scodes[k][2]) ? 4 : 0;
         n = int'(scodes[k]) - base + 1;
         chq.delete();
         wr(CFG, {30'h0, k[1], 1'b1}, OK);
         wr(CSR, 32'h20 | scodes[k], OK);
         poll_flag();
         chk("scan_group_end", 32'h1, 32'(chq.size() >= n));
         wait_for(2 * n + 1);
         for (int i = 0; i <= 2 * n; i++) begin
            chk("scan_ch", 32'(base + i % n), 32'(chq[i]));
         end
         wr(CSR, 32'(scodes[k]), OK);
         idle_check("scan_stop");
         chk("scan_abort", 32'(k + 1), 32'(n_abort));
         // a group end that meets the halting write leaves the flag set
         rd(CSR, 1'b0, OK);
         wr(CSR, 32'(scodes[k]), OK);
      end
      chq.delete();
      wr(CSR, 32'h67, OK);
      wait_for(2);
      stby <= 1'b1;
      @(posedge clk);
      stby <= 1'b0;
      idle_check("standby_stop");
      rdchk(CSR, 32'h00, "csr_standby");
      rdchk(CFG, 32'h00, "cfg_standby");
      wrap_up();
   end
endmodule
`default_nettype wire
